// >>> shared/hpm_params.svh
`ifndef HPM_PARAMS_SVH
`define HPM_PARAMS_SVH

// stabilisation lengths in cpu cycles
`define HPM_DELAY_SHORT   256
`define HPM_DELAY_LONG    4096
`define HPM_CNT_W         13

// halt instruction opcode
`define HPM_OP_HALT       8'h8E

// value forced into the interrupt mask on halt entry
`define HPM_IMASK_ENABLE  2'h2

// register byte offsets
`define HPM_ADDR_W        8
`define HPM_OFF_CTRL      8'h00
`define HPM_OFF_STATUS    8'h04
`define HPM_OFF_CAUSE     8'h08

// register fields
`define HPM_CTRL_TBIE     0
`define HPM_CTRL_RST      1'h0
`define HPM_ST_OSC        4
`define HPM_ST_CPU        5
`define HPM_ST_OPTL       6
`define HPM_ST_WDGO       7
`define HPM_ST_CNT        8
`define HPM_CAUSE_W       4
`define HPM_CAUSE_TB      0
`define HPM_CAUSE_EXT     1
`define HPM_CAUSE_RST     2
`define HPM_CAUSE_WDG     3

// bus responses
`define HPM_RESP_OKAY     2'h0
`define HPM_RESP_SLVERR   2'h2

`endif

// >>> shared/hpm_pkg.sv
package hpm_pkg;

    // power states of the sequencer
    typedef enum logic [2:0] {
        HPM_RUN,
        HPM_ACTIVE_HALT,
        HPM_FULL_HALT,
        HPM_STABILISE,
        HPM_GUARD,
        HPM_GUARD_HALT
    } hpm_state_t;

    typedef logic [31:0] hpm_word_t;

endpackage

// >>> shared/hpm_stab_if.sv
`timescale 1ns/100ps

// link between the sequencer and its stabilisation counter
interface hpm_stab_if #(parameter int CNT_W = 13);
    logic             start;
    logic             long_sel;
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] count;

    modport ctrl (output start, output long_sel, input busy, input done, input count);
    modport cnt  (input start, input long_sel, output busy, output done, output count);
endinterface

// >>> rtl/hpm_stab_counter.sv
`timescale 1ns/100ps
`include "hpm_params.svh"

module hpm_stab_counter
#(
    parameter int CNT_W     = `HPM_CNT_W,
    parameter int LEN_SHORT = `HPM_DELAY_SHORT,
    parameter int LEN_LONG  = `HPM_DELAY_LONG
)
(
    input wire logic mclk,
    input wire logic rst_n,
    hpm_stab_if.cnt  stab
);
    import hpm_pkg::*;

    logic [CNT_W-1:0] count_reg;
    logic             busy_reg;
    logic             done_reg;
    logic [CNT_W-1:0] last_cnt;

    // length latched at start
    logic             long_reg;

    assign last_cnt = long_reg ? CNT_W'(LEN_LONG - 1) : CNT_W'(LEN_SHORT - 1);

    // a start always restarts from zero, even mid-count
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            long_reg  <= 1'b0;
        end
        else if (stab.start)
        begin
            count_reg <= '0;
            busy_reg  <= 1'b1;
            done_reg  <= 1'b0;
            long_reg  <= stab.long_sel;
        end
        else if (busy_reg)
        begin
            count_reg <= count_reg + 1'b1;
            done_reg  <= (count_reg == last_cnt);
            busy_reg  <= (count_reg != last_cnt);
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end

    assign stab.busy  = busy_reg;
    assign stab.done  = done_reg;
    assign stab.count = count_reg;
endmodule // hpm_stab_counter

// >>> rtl/hpm_halt_ctrl.sv
`timescale 1ns/100ps
`include "hpm_params.svh"

// Functional notes
// - halt instruction with timebase interrupt enable set enters active-halt
// - halt instruction with that enable clear enters full halt, oscillator off
// - active-halt ends only on timebase interrupt or reset
// - timebase wake resumes at once; reset wake from active-halt waits
// - either halt entry forces interrupt mask to 10b; pending interrupt wakes
// - active-halt keeps only oscillator and timebase clocked
// - with timebase enable set, active-halt never causes watchdog reset
// - enable cleared inside post-wake window drops to halt for the remainder
// - full-halt exit restarts oscillator, waits 256 or 4096 cycles first
// - full halt stops the oscillator and every internally clocked peripheral
// - watchdog halt option decides whether halt with watchdog resets
// - servicing wake interrupt pushes condition codes, loads routine priority
// - opcode 8E is decoded as the halt instruction
// - only halt-capable interrupt subset or reset ends full halt
module hpm_halt_ctrl
(
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // register bus
    input  wire logic [`HPM_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire hpm_pkg::hpm_word_t      s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`HPM_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output hpm_pkg::hpm_word_t           s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // cpu core
    input  wire logic [7:0]              exec_opcode,
    input  wire logic                    exec_valid,
    input  wire logic [1:0]              irq_priority,
    output logic                         imask_load,
    output logic [1:0]                   imask_value,
    output logic                         cc_push,
    output logic                         irq_service,
    output logic                         reset_vector_fetch,
    // interrupt sources, reset logic, options
    input  wire logic                    timebase_irq,
    input  wire logic                    halt_wake_irq,
    input  wire logic                    reset_req,
    input  wire logic                    watchdog_active,
    input  wire logic                    watchdog_halt_option,
    input  wire logic                    opt_long_delay,
    output logic                         watchdog_reset,
    // clock gating
    output logic                         osc_enable,
    output logic                         timebase_clk_en,
    output logic                         periph_clk_en,
    output logic                         cpu_clk_en
);
    import hpm_pkg::*;

    hpm_state_t                state_reg;
    hpm_state_t                state_next;
    logic                      wake_rst_reg;
    logic                      timebase_irq_enable;
    logic [`HPM_CAUSE_W-1:0]   cause_reg;
    logic [`HPM_CAUSE_W-1:0]   cause_set;
    logic [1:0]                opt_meta_reg;
    logic [1:0]                opt_sync_reg;
    logic                      wdg_opt;
    logic                      long_opt;
    logic                      halt_exec;
    logic                      go_active;
    logic                      go_full;
    logic                      go_wdg;
    logic                      stab_start;
    logic                      wr_fire;
    logic                      aw_held_reg;
    logic                      w_held_reg;
    logic [`HPM_ADDR_W-1:0]    awaddr_reg;
    hpm_word_t                 wdata_reg;
    logic                      wstrb0_reg;
    hpm_word_t                 rd_word;
    logic                      rd_hit;

    hpm_stab_if #(.CNT_W(`HPM_CNT_W)) stab ();

    hpm_stab_counter u_stab
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .stab  (stab.cnt)
    );

    // static straps, two flops
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            opt_meta_reg <= 2'h0;
            opt_sync_reg <= 2'h0;
        end
        else
        begin
            opt_meta_reg <= {watchdog_halt_option, opt_long_delay};
            opt_sync_reg <= opt_meta_reg;
        end
    end

    assign wdg_opt  = opt_sync_reg[1];
    assign long_opt = opt_sync_reg[0];

    // halt decode, also honoured in the post-wake window
    assign halt_exec = exec_valid && (exec_opcode == `HPM_OP_HALT)
                       && (state_reg == HPM_RUN || state_reg == HPM_GUARD);
    assign go_active = halt_exec && timebase_irq_enable;
    // watchdog reset when option forbids halt, enable clear
    assign go_wdg    = halt_exec && !timebase_irq_enable
                       && watchdog_active && !wdg_opt;
    assign go_full   = halt_exec && !timebase_irq_enable && !go_wdg;

    // next state; reset tested before any wake
    always_comb
    begin
        state_next = state_reg;
        stab_start = 1'b0;
        unique case (state_reg)
            HPM_RUN:
            begin
                if (go_active)
                    state_next = HPM_ACTIVE_HALT;
                else if (go_full)
                    state_next = HPM_FULL_HALT;
            end
            HPM_ACTIVE_HALT:
            begin
                if (reset_req)
                begin
                    state_next = HPM_STABILISE;
                    stab_start = 1'b1;
                end
                else if (timebase_irq)
                begin
                    state_next = HPM_GUARD;
                    stab_start = 1'b1;
                end
            end
            HPM_FULL_HALT:
            begin
                if (reset_req || halt_wake_irq)
                begin
                    state_next = HPM_STABILISE;
                    stab_start = 1'b1;
                end
            end
            HPM_STABILISE:
            begin
                if (stab.done)
                    state_next = HPM_RUN;
            end
            HPM_GUARD:
            begin
                if (go_active)
                    state_next = HPM_ACTIVE_HALT;
                else if (go_full)
                    state_next = HPM_FULL_HALT;
                else if (!timebase_irq_enable && stab.busy)
                    state_next = HPM_GUARD_HALT;
                else if (stab.done)
                    state_next = HPM_RUN;
            end
            HPM_GUARD_HALT:
            begin
                if (reset_req)
                begin
                    state_next = HPM_STABILISE;
                    stab_start = 1'b1;
                end
                else if (stab.done)
                    state_next = HPM_RUN;
            end
            default:
            begin
                state_next = HPM_RUN;
            end
        endcase
    end

    assign stab.start    = stab_start;
    assign stab.long_sel = long_opt;

    // power state register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_reg <= HPM_RUN;
        else
            state_reg <= state_next;
    end

    // whether the wait ends in a reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            wake_rst_reg <= 1'b0;
        else if (stab_start)
            wake_rst_reg <= reset_req;
        else if (state_reg == HPM_STABILISE && reset_req)
            wake_rst_reg <= 1'b1;
    end

    // enables follow the state being entered
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            osc_enable      <= 1'b1;
            timebase_clk_en <= 1'b1;
            periph_clk_en   <= 1'b1;
            cpu_clk_en      <= 1'b1;
        end
        else
        begin
            osc_enable      <= (state_next != HPM_FULL_HALT);
            timebase_clk_en <= (state_next == HPM_RUN)
                               || (state_next == HPM_GUARD)
                               || (state_next == HPM_ACTIVE_HALT);
            periph_clk_en   <= (state_next == HPM_RUN)
                               || (state_next == HPM_GUARD);
            cpu_clk_en      <= (state_next == HPM_RUN)
                               || (state_next == HPM_GUARD);
        end
    end

    // one-cycle strobes to the cpu core
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            imask_load         <= 1'b0;
            imask_value        <= `HPM_IMASK_ENABLE;
            cc_push            <= 1'b0;
            irq_service        <= 1'b0;
            reset_vector_fetch <= 1'b0;
            watchdog_reset     <= 1'b0;
        end
        else
        begin
            imask_load         <= 1'b0;
            cc_push            <= 1'b0;
            irq_service        <= 1'b0;
            reset_vector_fetch <= 1'b0;
            watchdog_reset     <= go_wdg;
            if (go_active || go_full)
            begin
                imask_load  <= 1'b1;
                imask_value <= `HPM_IMASK_ENABLE;
            end
            else if (state_reg == HPM_ACTIVE_HALT && !reset_req && timebase_irq)
            begin
                // serviced at once, no wait on this path
                irq_service <= 1'b1;
                cc_push     <= 1'b1;
                imask_load  <= 1'b1;
                imask_value <= irq_priority;
            end
            else if (state_reg == HPM_STABILISE && stab.done)
            begin
                if (wake_rst_reg || reset_req)
                    reset_vector_fetch <= 1'b1;
                else
                begin
                    irq_service <= 1'b1;
                    cc_push     <= 1'b1;
                    imask_load  <= 1'b1;
                    imask_value <= irq_priority;
                end
            end
        end
    end

    // wake causes; a set beats a same-cycle clear
    always_comb
    begin
        cause_set = '0;
        cause_set[`HPM_CAUSE_TB]  = (state_reg == HPM_ACTIVE_HALT)
                                    && timebase_irq && !reset_req;
        cause_set[`HPM_CAUSE_EXT] = (state_reg == HPM_FULL_HALT)
                                    && halt_wake_irq && !reset_req;
        cause_set[`HPM_CAUSE_RST] = stab_start && reset_req;
        cause_set[`HPM_CAUSE_WDG] = go_wdg;
    end

    // ---- register bus slave
    // aw and w in either order, answered once both held
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // write channel capture
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb0_reg  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // write response; unmapped or read-only gives slverr
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `HPM_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg == `HPM_OFF_CTRL || awaddr_reg == `HPM_OFF_CAUSE)
                            ? `HPM_RESP_OKAY : `HPM_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // control register: timebase enable steers halt
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timebase_irq_enable <= `HPM_CTRL_RST;
        else if (wr_fire && wstrb0_reg && awaddr_reg == `HPM_OFF_CTRL)
            timebase_irq_enable <= wdata_reg[`HPM_CTRL_TBIE];
    end

    // cause register, write one to clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cause_reg <= '0;
        else if (wr_fire && wstrb0_reg && awaddr_reg == `HPM_OFF_CAUSE)
            cause_reg <= (cause_reg & ~wdata_reg[`HPM_CAUSE_W-1:0]) | cause_set;
        else
            cause_reg <= cause_reg | cause_set;
    end

    // read mux
    always_comb
    begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `HPM_OFF_CTRL:
                rd_word[`HPM_CTRL_TBIE] = timebase_irq_enable;
            `HPM_OFF_STATUS:
            begin
                rd_word[2:0]         = state_reg;
                rd_word[`HPM_ST_OSC] = osc_enable;
                rd_word[`HPM_ST_CPU] = cpu_clk_en;
                rd_word[`HPM_ST_OPTL] = long_opt;
                rd_word[`HPM_ST_WDGO] = wdg_opt;
                rd_word[`HPM_ST_CNT +: `HPM_CNT_W] = stab.count;
            end
            `HPM_OFF_CAUSE:
                rd_word[`HPM_CAUSE_W-1:0] = cause_reg;
            default:
                rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read response, one cycle after address
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `HPM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `HPM_RESP_OKAY : `HPM_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // hpm_halt_ctrl

// >>> bench/hpm_halt_ctrl_checker.sv
`timescale 1ns/100ps
`include "hpm_params.svh"

module hpm_halt_ctrl_checker
(
    input wire logic       mclk, rst_n, exec_valid, imask_load, cc_push, irq_service,
    input wire logic       timebase_irq, halt_wake_irq, reset_req, watchdog_active,
    input wire logic       watchdog_halt_option, watchdog_reset, osc_enable,
    input wire logic       timebase_clk_en, periph_clk_en, cpu_clk_en,
    input wire logic [7:0] exec_opcode,
    input wire logic [1:0] irq_priority, imask_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic halt_op, halt_d, in_ah;
    // halt only taken while cpu clocked
    assign halt_op = exec_valid && exec_opcode == `HPM_OP_HALT && cpu_clk_en;
    // active halt tracked from its entry edge
    always_ff @(posedge mclk)
    begin
        halt_d <= halt_op && rst_n;
        if (!rst_n || cpu_clk_en || timebase_irq || reset_req)
            in_ah <= 1'h0;
        else if (halt_d && osc_enable)
            in_ah <= 1'h1;
    end
    // full-halt exit: oscillator on, cpu held
    sequence s_full_wake;
        !osc_enable && (halt_wake_irq || reset_req);
    endsequence
    sequence s_stab_hold;
        (osc_enable && !cpu_clk_en)[*8];
    endsequence
    a_halt_mask_force:
        assert property (halt_op && !watchdog_active |=> imask_load && !cpu_clk_en
            && imask_value == `HPM_IMASK_ENABLE) else $error("halt entry wrong");
    a_full_wake_stab:
        assert property (s_full_wake |=> s_stab_hold) else $error("full halt exit early");
    a_full_hold:
        assert property (!osc_enable && !halt_wake_irq && !reset_req |=> !osc_enable)
            else $error("full halt left without cause");
    a_full_clocks_off:
        assert property (!osc_enable |-> !cpu_clk_en && !periph_clk_en && !timebase_clk_en)
            else $error("clock running in full halt");
    a_ah_clocks:
        assert property (in_ah |-> osc_enable && timebase_clk_en && !periph_clk_en)
            else $error("active halt clocks wrong");
    a_ah_hold:
        assert property (in_ah && !timebase_irq && !reset_req |=> !cpu_clk_en && osc_enable)
            else $error("active halt left without cause");
    a_tb_wake_fast:
        assert property (in_ah && timebase_irq && !reset_req |=> irq_service && cpu_clk_en)
            else $error("timebase wake late");
    a_wdog_cause:
        assert property (watchdog_reset |-> $past(halt_op) && cpu_clk_en && osc_enable)
            else $error("watchdog reset without halt");
    a_wdog_tolerate:
        assert property (halt_op && watchdog_halt_option |=> !watchdog_reset)
            else $error("watchdog reset despite option");
    a_service_push:
        assert property (irq_service |-> cc_push && imask_load && imask_value == irq_priority)
            else $error("service without push");
    a_opcode_other:
        assert property (exec_valid && exec_opcode != `HPM_OP_HALT && cpu_clk_en |=> cpu_clk_en)
            else $error("other opcode stopped cpu");
endmodule // hpm_halt_ctrl_checker

bind hpm_halt_ctrl hpm_halt_ctrl_checker hpm_halt_ctrl_checker_inst (.*);

// >>> bench/hpm_cpu_model.sv
`timescale 1ns/100ps

module hpm_cpu_model
(
    input wire logic   mclk, irq_service, reset_vector_fetch,
    output logic [7:0] exec_opcode,
    output logic       exec_valid, timebase_irq, halt_wake_irq, reset_req, watchdog_active,
    output logic [1:0] irq_priority
);
    initial
    begin
        {exec_opcode, exec_valid, timebase_irq, halt_wake_irq} = 11'h0;
        {reset_req, watchdog_active, irq_priority} = 4'h0;
    end
    // request latches drop when serviced
    always @(posedge mclk)
    begin
        if (irq_service)
            {timebase_irq, halt_wake_irq} <= 2'h0;
        if (reset_vector_fetch)
            reset_req <= 1'h0;
    end
    // one opcode; bus shows junk once released
    task automatic exec(input logic [7:0] op);
        exec_opcode <= op;
        exec_valid  <= 1'h1;
        @(posedge mclk);
        exec_valid  <= 1'h0;
        exec_opcode <= ~op;
    endtask
    // v = {timebase, wake, reset, watchdog, priority[1:0]}
    task automatic drive(input logic [5:0] v);
        {timebase_irq, halt_wake_irq, reset_req, watchdog_active, irq_priority} <= v;
    endtask
endmodule // hpm_cpu_model

// >>> bench/test_hpm_halt_ctrl.sv
`timescale 1ns/100ps
`include "hpm_params.svh"

module test_hpm_halt_ctrl
import hpm_pkg::*;
;
    logic       mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic       s_axi_rready, imask_load, cc_push, irq_service, reset_vector_fetch;
    logic       exec_valid, timebase_irq, halt_wake_irq, reset_req, watchdog_active;
    logic       watchdog_halt_option, opt_long_delay, watchdog_reset, osc_enable;
    logic       timebase_clk_en, periph_clk_en, cpu_clk_en;
    logic [7:0] s_axi_awaddr, s_axi_araddr, exec_opcode;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_priority, imask_value;
    hpm_word_t  s_axi_wdata, s_axi_rdata;
    int         fail_count, num_checks;
    hpm_word_t  d;
    logic [1:0] r;
    int         n, len;
    wire  [3:0] evt = {!cpu_clk_en, cpu_clk_en, reset_vector_fetch, irq_service};

    hpm_halt_ctrl hpm_halt_ctrl_inst (.*);
    hpm_cpu_model hpm_cpu_model_inst (.*);

    initial
    begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // a spent bound ends the run
    task automatic guard(input int n, lim);
        if (n >= lim)
        begin
            fail_count++;
            $display("BAD timeout exp %0d seen %0d", lim, n);
            final_report();
        end
    endtask

    // counts edges until the chosen event is sampled high
    task automatic wait_on(input int s, lim, output int n);
        n = 0;
        @(posedge mclk);
        while (evt[s] !== 1'h1 && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
        guard(n, lim);
    endtask

    task automatic drv(input logic [5:0] v);
        hpm_cpu_model_inst.drive(v);
    endtask

    task automatic do_halt();
        hpm_cpu_model_inst.exec(`HPM_OP_HALT);
    endtask

    // one access; a write offers aw and w together, each held until taken
    task automatic axi(input bit wr, input logic [7:0] a, input hpm_word_t di,
                       output hpm_word_t d, output logic [1:0] r,
                       input logic [3:0] s = 4'hF);
        int k;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, di, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'h1 && k < 50);
        {d, r} = wr ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(posedge mclk);
        guard(k, 50);
    endtask

    task automatic t_regs();
        {watchdog_halt_option, opt_long_delay} <= 2'h0;
        axi(0, `HPM_OFF_CTRL, 0, d, r);
        chk("ctrl_rst", d, 32'h0);
        axi(1, `HPM_OFF_STATUS, 32'h1, d, r);
        chk("ro_wr", r, `HPM_RESP_SLVERR);
        axi(0, 8'h0C, 0, d, r);
        chk("unmapped", r, `HPM_RESP_SLVERR);
        axi(1, `HPM_OFF_CTRL, 32'h1, d, r, 4'hE);
        axi(0, `HPM_OFF_CTRL, 0, d, r);
        chk("strobe_off", d, 32'h0);
    endtask

    // active halt, timebase wake, enable cleared in window
    task automatic t_active();
        axi(1, `HPM_OFF_CTRL, 32'h1, d, r);
        drv(6'h05);
        do_halt();
        @(posedge mclk);
        chk("ah_clk", {osc_enable, timebase_clk_en, periph_clk_en, cpu_clk_en}, 4'hC);
        chk("ah_wdog", watchdog_reset, 1'h0);
        axi(0, `HPM_OFF_STATUS, 0, d, r);
        chk("ah_state", d[5:0], 6'h11);
        drv(6'h15);
        repeat (4) @(posedge mclk);
        chk("ah_hold", cpu_clk_en, 1'h0);
        drv(6'h25);
        wait_on(0, 10, n);
        chk("tb_wake", n <= 2, 1'h1);
        chk("tb_push", {cc_push, imask_value}, 3'h5);
        axi(1, `HPM_OFF_CTRL, 32'h0, d, r);
        wait_on(3, 10, n);
        wait_on(2, 300, n);
        chk("guard_len", n >= 230 && n <= 256, 1'h1);
        drv(6'h00);
    endtask

    task automatic t_wdog();
        drv(6'h04);
        hpm_cpu_model_inst.exec(8'h8F);
        @(posedge mclk);
        chk("other_op", cpu_clk_en, 1'h1);
        do_halt();
        @(posedge mclk);
        chk("wdog_rst", {watchdog_reset, cpu_clk_en}, 2'h3);
        watchdog_halt_option <= 1'h1;
        repeat (4) @(posedge mclk);
        do_halt();
        @(posedge mclk);
        chk("wdog_ok", {watchdog_reset, osc_enable}, 2'h0);
        drv(6'h14);
        wait_on(0, 300, n);
        drv(6'h00);
    endtask

    // full halt, both wait lengths
    task automatic t_full();
        for (int k = 0; k < 2; k++)
        begin
            opt_long_delay <= k[0];
            repeat (4) @(posedge mclk);
            do_halt();
            @(posedge mclk);
            chk("fh_clk", {osc_enable, timebase_clk_en, periph_clk_en}, 3'h0);
            axi(0, `HPM_OFF_STATUS, 0, d, r);
            chk("fh_state", d[5:0], 6'h02);
            drv(6'h20);
            repeat (4) @(posedge mclk);
            chk("fh_hold", osc_enable, 1'h0);
            drv(6'h10);
            wait_on(0, 5000, n);
            len = k ? `HPM_DELAY_LONG : `HPM_DELAY_SHORT;
            chk("stab_len", n >= len && n <= len + 4, 1'h1);
        end
        opt_long_delay <= 1'h0;
        repeat (4) @(posedge mclk);
    endtask

    // reset with wake, from full then active halt
    task automatic t_reset();
        for (int c = 0; c < 2; c++)
        begin
            axi(1, `HPM_OFF_CTRL, c, d, r);
            do_halt();
            @(posedge mclk);
            drv(6'h18);
            wait_on(1, 300, n);
            chk("rst_wake", {n >= 256, irq_service}, 2'h2);
            drv(6'h00);
        end
    endtask

    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        fail_count = 0;
        num_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (4) @(posedge mclk);
        t_regs();
        t_active();
        t_wdog();
        t_full();
        t_reset();
        final_report();
    end
endmodule // test_hpm_halt_ctrl
